// [logic/rxdesc_pkg.sv]
package rxdesc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (APB byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] LIST_OFS = 8'h04;
  localparam logic [7:0] SYSB_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;

  // ----------------------------------------------------------------------
  // Operating mode and status register bits
  // ----------------------------------------------------------------------
  localparam int MODE_START = 1;
  localparam int MODE_RUNT = 3;
  localparam int MODE_NOCHAIN = 7;
  localparam int MODE_DT = 8;
  localparam int STATB_WD = 5;

  // ----------------------------------------------------------------------
  // Receive status word fields
  // ----------------------------------------------------------------------
  localparam int ST_OVF = 0;
  localparam int ST_CRC = 1;
  localparam int ST_DRIB = 2;
  localparam int ST_TN = 3;
  localparam int ST_FT = 5;
  localparam int ST_CS = 6;
  localparam int ST_TL = 7;
  localparam int ST_LS = 8;
  localparam int ST_FS = 9;
  localparam int ST_BO = 10;
  localparam int ST_RF = 11;
  localparam int ST_DT = 12;
  localparam int ST_LE = 14;
  localparam int ST_ES = 15;
  localparam int ST_FL = 16;
  localparam int ST_OW = 31;

  // ----------------------------------------------------------------------
  // Control, size/offset and page table entry fields
  // ----------------------------------------------------------------------
  localparam int CTL_VT = 29;
  localparam int CTL_VA = 30;
  localparam int CTL_CA = 31;
  localparam int PO_MSB = 8;
  localparam int BS_LSB = 16;
  localparam int BS_MSB = 30;
  localparam int PTE_VALID = 31;
  localparam int PFN_MSB = 22;

  // ----------------------------------------------------------------------
  // Counts and limits
  // ----------------------------------------------------------------------
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0010;
  localparam logic [14:0] MAX_FRAME = 15'h05EE;
  localparam logic [15:0] TYPE_MIN = 16'h05DC;
  localparam logic [14:0] FT_MIN_LEN = 15'h000E;
  localparam logic [2:0] DRIB_MIN = 3'h2;

  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_FETCH = 9'h002,
    S_PTE = 9'h004,
    S_RECV = 9'h008,
    S_WRITE = 9'h010,
    S_FULL = 9'h020,
    S_STAT = 9'h040,
    S_DRAIN = 9'h080,
    S_SPARE = 9'h100
  } state_t;

endpackage

// [logic/rx_desc_engine.sv]
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ns
// Notes on behaviour
// [RQ1] Status bit 0 flags buffer data corrupted by receive FIFO overflow.
// [RQ2] Status bit 1 flags a frame failing its CRC check.
// [RQ3] Status bit 2 set only with more than two dribbling bits.
// [RQ4] CRC covers whole bytes; dribble plus CRC means alignment error.
// [RQ5] Bit 3 flags failed translation of a virtual buffer; reception continues.
// [RQ6] Bit 5 marks Ethernet type frames; meaningless below 14 bytes.
// [RQ7] Bit 6 flags a collision after the first 64 bytes.
// [RQ8] Bit 7 flags frames over 1518 bytes without truncating them.
// [RQ9] Bit 9 marks first segment, bit 8 marks last segment with valid status.
// [RQ10] Bit 10 flags truncation by small buffer, only with chaining disabled.
// [RQ11] Bit 11 flags runts; runts stored only with mode bit 3 set; the code drops only runts that end in their first buffer.
// [RQ12] Bits 13:12 mirror operating mode bits 9:8.
// [RQ13] Bit 14 flags truncation by unowned next descriptor or watchdog.
// [RQ14] Bit 15 is the OR of the error flags.
// [RQ15] Bits 30:16 carry the frame length in bytes.
// [RQ16] Bit 31 ownership; device clears it when done with the descriptor.
// [RQ17] Control bits 30 and 29 select physical, system or physical table entry.
// [RQ18] Chain bit follows word three; self-pointing chain counts host-owned.
// [RQ19] Page offset from word two bits 8:0; buffers word-aligned.
// [RQ20] Never store beyond the buffer size in word two bits 30:16.
// [RQ21] Word three is PTE address, buffer address or next descriptor.
// [RQ22] Flags made meaningless by the completion condition are written zero.
// [RQ23] Only word zero is written back, unused bits as zero.
// [RQ24] Buffer data writes complete before the status write-back.
module rx_desc_engine (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output logic [3:0] mem_be,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  input wire logic rx_crc_bad,
  input wire logic [2:0] rx_dribble_bits,
  input wire logic rx_late_collision,
  input wire logic rx_runt,
  input wire logic rx_fifo_overflow,
  input wire logic rx_watchdog
);

  typedef struct packed {
    rxdesc_pkg::state_t st;
    logic [1:0] widx;
    logic [31:0] cur;
    logic [31:0] stat_at;
    logic own;
    logic [2:0] ctl;
    logic [14:0] bsize;
    logic [8:0] po;
    logic [31:0] adw;
    logic [31:0] baddr;
    logic [14:0] bcnt;
    logic [14:0] flen;
    logic [15:0] ltype;
    logic [31:0] word;
    logic [3:0] be;
    logic first;
    logic done;
    logic drop;
    logic e_ov;
    logic e_ce;
    logic e_cs;
    logic e_rf;
    logic e_wd;
    logic [2:0] e_db;
    logic le;
    logic bo;
    logic tn;
    logic start;
    logic pass_runt;
    logic nochain;
    logic [1:0] dt;
    logic [31:0] sysb;
    logic wd_st;
    logic [15:0] miss;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic mreq;
    logic mwe;
    logic [31:0] maddr;
    logic [31:0] mwdata;
    logic [3:0] mbe;
    logic rdy;
  } regs_t;

  localparam int VT_I = rxdesc_pkg::CTL_VT - rxdesc_pkg::CTL_VT;
  localparam int VA_I = rxdesc_pkg::CTL_VA - rxdesc_pkg::CTL_VT;
  localparam int CA_I = rxdesc_pkg::CTL_CA - rxdesc_pkg::CTL_VT;
  localparam int PTE_VALID_I = rxdesc_pkg::PTE_VALID;

  regs_t r;
  regs_t n;
  logic go_buf;
  logic go_stat;
  logic ack;
  logic acc;
  logic stat_wr;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] mode_word(input regs_t s);
    logic [31:0] w;
    w = 32'h0;
    w[rxdesc_pkg::MODE_START] = s.start;
    w[rxdesc_pkg::MODE_RUNT] = s.pass_runt;
    w[rxdesc_pkg::MODE_NOCHAIN] = s.nochain;
    w[rxdesc_pkg::MODE_DT +: 2] = s.dt;
    return w;
  endfunction

  // Ownership always returns to the host; unused bits stay zero
  function automatic logic [31:0] status_word(input regs_t s);
    logic [31:0] w;
    logic bad_dc;
    w = 32'h0;
    bad_dc = 1'b0;
    w[rxdesc_pkg::ST_FS] = s.first; // RQ9
    w[rxdesc_pkg::ST_DT +: 2] = s.dt; // RQ12
    if (s.done) begin
      // Conditions that make dribble and CRC meaningless
      bad_dc = s.e_ov | s.e_cs | s.e_rf | s.e_wd; // RQ22
      w[rxdesc_pkg::ST_LS] = 1'b1; // RQ9
      w[rxdesc_pkg::ST_OVF] = s.e_ov; // RQ1
      w[rxdesc_pkg::ST_CRC] = s.e_ce & ~bad_dc; // RQ2 RQ4
      w[rxdesc_pkg::ST_DRIB] = (s.e_db > rxdesc_pkg::DRIB_MIN) & ~bad_dc; // RQ3 RQ4
      w[rxdesc_pkg::ST_TN] = s.tn; // RQ5
      w[rxdesc_pkg::ST_FT] = (s.ltype > rxdesc_pkg::TYPE_MIN) &&
                             (s.flen >= rxdesc_pkg::FT_MIN_LEN); // RQ6
      w[rxdesc_pkg::ST_CS] = s.e_cs & ~s.e_ov & ~s.e_wd; // RQ7
      w[rxdesc_pkg::ST_TL] = s.flen > rxdesc_pkg::MAX_FRAME; // RQ8
      w[rxdesc_pkg::ST_BO] = s.bo; // RQ10
      w[rxdesc_pkg::ST_RF] = s.e_rf & ~s.e_ov; // RQ11
      w[rxdesc_pkg::ST_LE] = s.le; // RQ13
      w[rxdesc_pkg::ST_ES] = w[rxdesc_pkg::ST_OVF] | w[rxdesc_pkg::ST_CRC] |
                             w[rxdesc_pkg::ST_TN] | w[rxdesc_pkg::ST_CS] |
                             w[rxdesc_pkg::ST_TL] | w[rxdesc_pkg::ST_RF] |
                             w[rxdesc_pkg::ST_LE]; // RQ14
      w[rxdesc_pkg::ST_FL +: 15] = s.flen; // RQ15
    end
    w[rxdesc_pkg::ST_OW] = 1'b0; // RQ16
    return w;
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = r;
    go_buf = 1'b0;
    go_stat = 1'b0;
    ack = r.mreq && mem_ack;
    acc = rx_valid && r.rdy;
    // APB: answer prepared in setup, write lands at the access edge
    n.pready = psel && !penable;
    if (psel && !penable) begin
      n.pslverr = 1'b0;
      case (paddr)
        rxdesc_pkg::MODE_OFS: n.prdata = mode_word(r);
        rxdesc_pkg::LIST_OFS: n.prdata = r.cur;
        rxdesc_pkg::SYSB_OFS: n.prdata = r.sysb;
        rxdesc_pkg::STAT_OFS: n.prdata = {r.miss, 10'h000, r.wd_st, 4'h0, r.st != rxdesc_pkg::S_IDLE};
        default: begin
          n.prdata = 32'h0;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && r.pready && pwrite) begin
      case (paddr)
        rxdesc_pkg::MODE_OFS: begin
          n.start = pwdata[rxdesc_pkg::MODE_START];
          n.pass_runt = pwdata[rxdesc_pkg::MODE_RUNT];
          n.nochain = pwdata[rxdesc_pkg::MODE_NOCHAIN];
          n.dt = pwdata[rxdesc_pkg::MODE_DT +: 2];
        end
        // Moving the list pointer mid-frame would orphan a descriptor
        rxdesc_pkg::LIST_OFS: if (r.st == rxdesc_pkg::S_IDLE) n.cur = pwdata;
        rxdesc_pkg::SYSB_OFS: n.sysb = pwdata;
        rxdesc_pkg::STAT_OFS: if (pwdata[rxdesc_pkg::STATB_WD]) n.wd_st = 1'b0;
        default: ;
      endcase
    end
    if (ack) n.mreq = 1'b0;

    unique case (r.st)
      rxdesc_pkg::S_IDLE: begin
        if (r.start && rx_valid) begin
          n.first = 1'b1;
          n.done = 1'b0;
          n.drop = 1'b0;
          n.flen = 15'h0000;
          n.ltype = 16'h0000;
          n.bcnt = 15'h0000;
          // End status of the previous frame must not leak into this one
          {n.e_ov, n.e_ce, n.e_cs, n.e_rf, n.e_wd} = 5'h00;
          n.e_db = 3'h0;
          {n.le, n.bo, n.tn} = 3'h0;
          n.mreq = 1'b1;
          n.mwe = 1'b0;
          n.maddr = r.cur;
          n.widx = 2'h0;
          n.st = rxdesc_pkg::S_FETCH;
        end
      end
      rxdesc_pkg::S_FETCH: begin
        if (ack) begin
          unique case (r.widx)
            2'h0: n.own = mem_rdata[rxdesc_pkg::ST_OW];
            2'h1: n.ctl = mem_rdata[rxdesc_pkg::CTL_CA:rxdesc_pkg::CTL_VT];
            2'h2: begin
              n.bsize = mem_rdata[rxdesc_pkg::BS_MSB:rxdesc_pkg::BS_LSB];
              n.po = mem_rdata[rxdesc_pkg::PO_MSB:0]; // RQ19
            end
            2'h3: n.adw = mem_rdata; // RQ21
          endcase
          if (r.widx != 2'h3) begin
            n.widx = r.widx + 2'h1;
            n.mreq = 1'b1;
            n.maddr = r.cur + {28'h0000000, n.widx, 2'h0};
          end else if (r.own && !(r.ctl[CA_I] && mem_rdata == r.cur)) begin // RQ18
            if (r.ctl[CA_I]) begin
              // Chain descriptor: its word zero is left untouched
              n.cur = mem_rdata; // RQ18
              n.widx = 2'h0;
              n.mreq = 1'b1;
              n.maddr = mem_rdata;
            end else if (!r.first || r.bcnt != 15'h0000) begin
              go_stat = 1'b1; // Close the previous segment first
            end else begin
              go_buf = 1'b1;
            end
          end else if (r.first && r.flen == 15'h0000) begin
            n.miss = r.miss + 16'h0001;
            n.st = rxdesc_pkg::S_DRAIN;
          end else begin
            n.le = 1'b1; // RQ13
            n.done = 1'b1;
            n.drop = 1'b1;
            go_stat = 1'b1;
          end
        end
      end
      rxdesc_pkg::S_PTE: begin
        if (ack) begin
          if (mem_rdata[PTE_VALID_I]) begin
            n.baddr = {mem_rdata[rxdesc_pkg::PFN_MSB:0], r.po}; // RQ19
            n.st = (r.bsize == 15'h0000) ? rxdesc_pkg::S_FULL : rxdesc_pkg::S_RECV;
          end else begin
            // Rest of this frame is dropped; the next frame gets a new descriptor
            n.tn = 1'b1; // RQ5
            n.done = 1'b1;
            n.drop = 1'b1;
            go_stat = 1'b1;
          end
        end
      end
      rxdesc_pkg::S_RECV: begin
        if (acc) begin
          n.word[{r.bcnt[1:0], 3'h0} +: 8] = rx_data;
          n.be[r.bcnt[1:0]] = 1'b1;
          n.bcnt = r.bcnt + 15'h0001;
          n.flen = r.flen + 15'h0001;
          if (r.flen == 15'h000C) n.ltype[15:8] = rx_data;
          if (r.flen == 15'h000D) n.ltype[7:0] = rx_data;
          if (rx_last) begin
            n.done = 1'b1;
            n.e_ov = rx_fifo_overflow; // RQ1
            n.e_ce = rx_crc_bad; // RQ2
            n.e_db = rx_dribble_bits; // RQ3
            n.e_cs = rx_late_collision; // RQ7
            n.e_rf = rx_runt; // RQ11
            n.e_wd = rx_watchdog;
            n.le = r.le | rx_watchdog; // RQ13
          end
          if (rx_last || r.bcnt[1:0] == 2'h3 || n.bcnt == r.bsize) begin
            n.mreq = 1'b1;
            n.mwe = 1'b1;
            n.maddr = r.baddr + {17'h00000, r.bcnt[14:2], 2'h0}; // RQ20
            n.mwdata = n.word;
            n.mbe = n.be;
            n.st = rxdesc_pkg::S_WRITE;
          end
        end
      end
      rxdesc_pkg::S_WRITE: begin
        if (ack) begin
          n.word = 32'h0;
          n.be = 4'h0;
          if (r.done && r.e_rf && !r.pass_runt && r.first) begin
            n.st = rxdesc_pkg::S_IDLE; // RQ11
          end else if (r.done) begin
            go_stat = 1'b1; // RQ24
          end else begin
            n.st = (r.bcnt == r.bsize) ? rxdesc_pkg::S_FULL : rxdesc_pkg::S_RECV; // RQ20
          end
        end
      end
      rxdesc_pkg::S_FULL: begin
        // Peek without taking: only a further byte proves the frame continues
        if (rx_valid) begin
          if (r.nochain) begin
            n.bo = 1'b1; // RQ10
            n.done = 1'b1;
            n.drop = 1'b1;
            go_stat = 1'b1;
          end else begin
            n.cur = r.cur + rxdesc_pkg::DESC_STRIDE;
            n.widx = 2'h0;
            n.mreq = 1'b1;
            n.mwe = 1'b0;
            n.maddr = n.cur;
            n.st = rxdesc_pkg::S_FETCH;
          end
        end
      end
      rxdesc_pkg::S_STAT: begin
        if (ack) begin
          if (!r.done) begin
            n.first = 1'b0;
            go_buf = 1'b1;
          end else begin
            n.cur = (r.stat_at == r.cur) ? r.cur + rxdesc_pkg::DESC_STRIDE : r.cur;
            n.st = r.drop ? rxdesc_pkg::S_DRAIN : rxdesc_pkg::S_IDLE;
          end
        end
      end
      rxdesc_pkg::S_DRAIN: begin
        if (acc && rx_last) n.st = rxdesc_pkg::S_IDLE;
      end
      default: n.st = rxdesc_pkg::S_IDLE;
    endcase

    if (go_stat) begin
      n.mreq = 1'b1;
      n.mwe = 1'b1;
      n.maddr = n.stat_at; // RQ23
      n.mwdata = status_word(n);
      n.mbe = 4'hF;
      n.st = rxdesc_pkg::S_STAT;
    end
    if (go_buf) begin
      n.stat_at = n.cur;
      n.bcnt = 15'h0000;
      if (n.ctl[VA_I]) begin // RQ17
        n.mreq = 1'b1;
        n.mwe = 1'b0;
        n.maddr = n.ctl[VT_I] ? n.adw : r.sysb + n.adw; // RQ17
        n.st = rxdesc_pkg::S_PTE;
      end else begin
        n.baddr = n.adw; // RQ21
        n.st = (n.bsize == 15'h0000) ? rxdesc_pkg::S_FULL : rxdesc_pkg::S_RECV;
      end
    end
    // Set wins over a simultaneous write-one-to-clear
    if (r.st == rxdesc_pkg::S_RECV && acc && rx_last && rx_watchdog) n.wd_st = 1'b1; // RQ13
    n.rdy = (n.st == rxdesc_pkg::S_RECV) || (n.st == rxdesc_pkg::S_DRAIN);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.st <= rxdesc_pkg::S_IDLE;
    end else begin
      r <= n;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign mem_req = r.mreq;
  assign mem_we = r.mwe;
  assign mem_addr = r.maddr;
  assign mem_wdata = r.mwdata;
  assign mem_be = r.mbe;
  assign rx_ready = r.rdy;
  assign stat_wr = r.st == rxdesc_pkg::S_STAT && r.mreq && mem_ack;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);

  AST_OW_CLEARED: assert property (stat_wr |-> !r.mwdata[31]) // RQ16
    else $error("status write leaves ownership set");
  AST_ES_OR: assert property (stat_wr |-> r.mwdata[15] ==
    |{r.mwdata[0], r.mwdata[1], r.mwdata[3], r.mwdata[6], r.mwdata[7],
      r.mwdata[11], r.mwdata[14]}) // RQ14
    else $error("error summary differs from flag OR");
  AST_BO_NOCHAIN: assert property (stat_wr && r.mwdata[10] |-> r.nochain) // RQ10
    else $error("buffer truncation flagged with chaining on");
  AST_DT_MIRROR: assert property (stat_wr |-> r.mwdata[13:12] == r.dt) // RQ12
    else $error("data type does not mirror mode bits");
  AST_DRIB_MIN: assert property (stat_wr && r.mwdata[2] |-> r.e_db > 3'h2) // RQ3
    else $error("dribble flagged with two or fewer bits");
  AST_TN_VIRTUAL: assert property (stat_wr && r.mwdata[3] |-> r.ctl[VA_I]) // RQ5
    else $error("translation flag on a physical buffer");
  AST_IN_BUFFER: assert property (r.st == rxdesc_pkg::S_WRITE && r.mreq |->
    (r.maddr - r.baddr) < {17'h00000, r.bsize}) // RQ20
    else $error("data write outside the buffer");
  AST_WORD0_ONLY: assert property (r.st == rxdesc_pkg::S_STAT && r.mreq |->
    r.maddr == r.stat_at && r.mbe == 4'hF && r.mwe) // RQ23
    else $error("write-back not a full word zero write");
  AST_CHAIN_SELF: assert property (r.st == rxdesc_pkg::S_FETCH && ack &&
    r.widx == 2'h3 && r.ctl[CA_I] && mem_rdata == r.cur |=>
    r.st inside {rxdesc_pkg::S_DRAIN, rxdesc_pkg::S_STAT}) // RQ18
    else $error("self-pointing chain descriptor followed");
  AST_DATA_FIRST: assert property ($rose(r.st == rxdesc_pkg::S_STAT) && r.done
    && !r.tn && !r.le && !r.bo |-> $past(r.st) == rxdesc_pkg::S_WRITE) // RQ24
    else $error("status written before data completed");

  COV_LAST: cover property (stat_wr && r.mwdata[8]);
  COV_MIDDLE: cover property (stat_wr && !r.mwdata[8]);
  COV_CHAIN: cover property (r.st == rxdesc_pkg::S_FETCH && ack && r.widx == 2'h3
    && r.ctl[CA_I] && r.own);
  COV_TN: cover property (stat_wr && r.mwdata[3]);

endmodule

// [verif/host_mem.sv]
`timescale 1ns/1ns
// ----------------------------------------------------------------------
// Host memory holding descriptor lists and buffers
// ----------------------------------------------------------------------
module host_mem (
  input wire logic core_clk,
  input wire logic [3:0] ack_delay,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] mem_be,
  output logic mem_ack,
  output logic [31:0] mem_rdata
);
  logic [31:0] mem [0:1023];
  logic [3:0] cnt;

  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    cnt = 4'h0;
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 32'hC0DE_0000 | i;
    end
  end

  // Read data is only good with the ack; it toggles while idle and after each ack so stale use shows
  always @(posedge core_clk) begin
    if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      cnt <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (cnt >= ack_delay) begin
      mem_ack <= 1'b1;
      if (mem_we) begin
        for (int b = 0; b < 4; b++) begin
          if (mem_be[b]) begin
            mem[mem_addr[11:2]][8*b +: 8] <= mem_wdata[8*b +: 8];
          end
        end
      end else begin
        mem_rdata <= mem[mem_addr[11:2]];
      end
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// [verif/tb_top.sv]
`timescale 1ns/1ns
module tb_top;
  logic core_clk;
  logic reset;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  logic mem_req, mem_we, mem_ack;
  logic [31:0] mem_addr, mem_wdata, mem_rdata;
  logic [3:0] mem_be, ack_delay;
  logic rx_valid, rx_ready, rx_last;
  logic [7:0] rx_data;
  logic [2:0] rx_dribble_bits;
  logic [4:0] rx_flags;
  logic [31:0] rd;
  logic [15:0] miss;
  logic err;
  int mismatches = 0;
  int num_checks = 0;

  rx_desc_engine i_dut (.core_clk(core_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_be(mem_be), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_last(rx_last),
    .rx_crc_bad(rx_flags[0]), .rx_dribble_bits(rx_dribble_bits),
    .rx_late_collision(rx_flags[1]), .rx_runt(rx_flags[2]),
    .rx_fifo_overflow(rx_flags[3]), .rx_watchdog(rx_flags[4]));

  host_mem i_mem (.core_clk(core_clk), .ack_delay(ack_delay), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_be(mem_be),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic [7:0] bval(input int i, input logic [7:0] p);
    // Bytes 12 and 13 form a type field above the length limit
    return (i == 12) ? 8'h08 : (i == 13) ? 8'h00 : p + i[7:0];
  endfunction

  function automatic logic [31:0] word(input logic [31:0] a);
    return i_mem.mem[a[11:2]];
  endfunction

  task automatic put_desc(input logic [31:0] a, input logic [31:0] w0, input logic [31:0] w1,
                          input logic [31:0] w2, input logic [31:0] w3);
    i_mem.mem[a[11:2]] = w0;
    i_mem.mem[a[11:2] + 10'h1] = w1;
    i_mem.mem[a[11:2] + 10'h2] = w2;
    i_mem.mem[a[11:2] + 10'h3] = w3;
  endtask

  task automatic chk_buf(input logic [31:0] a, input int n, input logic [7:0] p);
    for (int j = 0; j < n; j++) begin
      chk("buffer", word(a + 4 * j), {bval(4*j+3, p), bval(4*j+2, p), bval(4*j+1, p),
          bval(4*j, p)});
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int t;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle;
    int t;
    t = 0;
    do begin
      apb(1'b0, rxdesc_pkg::STAT_OFS, 32'h0000_0000);
      t++;
    end while (rd[0] !== 1'b0 && t < 100);
  endtask

  // Status inputs stay put for the whole frame; only the last byte samples them
  task automatic send_frame(input int len, input logic [7:0] p, input logic [2:0] drib,
                            input logic [4:0] fl);
    int i;
    int t;
    @(posedge core_clk);
    i = 0;
    t = 0;
    rx_valid <= 1'b1;
    rx_data <= bval(0, p);
    rx_last <= (len == 1);
    rx_dribble_bits <= drib;
    rx_flags <= fl;
    while (i < len && t < 3000) begin
      @(posedge core_clk);
      t++;
      if (rx_ready === 1'b1) begin
        i++;
        if (i < len) begin
          rx_data <= bval(i, p);
          rx_last <= (i == len - 1);
        end
      end
    end
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, rx_valid, rx_last} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rx_data = 8'h00;
    rx_dribble_bits = 3'h0;
    rx_flags = 5'h00;
    ack_delay = 4'h0;
    repeat (3) @(posedge core_clk);
    reset <= 1'b0;
    apb(1'b0, rxdesc_pkg::MODE_OFS, 32'h0000_0000);
    chk("mode_reset", rd, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped_err", {31'h0, err}, 32'h0000_0001);
    put_desc(32'h100, 32'h8000_0000, 32'h0, 32'h0020_0000, 32'h400);
    put_desc(32'h110, 32'h8000_0000, 32'h0, 32'h0010_0000, 32'h440);
    put_desc(32'h120, 32'h0, 32'h0, 32'h0, 32'h0);
    i_mem.mem[32'h450 >> 2] = 32'h5A5A_5A5A;
    apb(1'b1, rxdesc_pkg::LIST_OFS, 32'h0000_0100);
    apb(1'b1, rxdesc_pkg::MODE_OFS, 32'h0000_0102);
    send_frame(16, 8'h10, 3'h3, 5'h01);
    wait_idle;
    chk("status_f1", word(32'h100), 32'h0010_9326);
    chk_buf(32'h400, 4, 8'h10);
    // Truncation by an unowned next descriptor, with a slow memory
    ack_delay <= 4'h2;
    send_frame(20, 8'h40, 3'h2, 5'h00);
    wait_idle;
    chk("status_f2", word(32'h110) & 32'h8000_FFFF, 32'h0000_D320);
    chk_buf(32'h440, 4, 8'h40);
    chk("past_buffer", word(32'h450), 32'h5A5A_5A5A);
    apb(1'b0, rxdesc_pkg::LIST_OFS, 32'h0000_0000);
    chk("list_hold", rd, 32'h0000_0120);
    miss = rd[31:16];
    apb(1'b0, rxdesc_pkg::STAT_OFS, 32'h0000_0000);
    miss = rd[31:16];
    send_frame(4, 8'h60, 3'h0, 5'h00);
    wait_idle;
    chk("missed", {16'h0, rd[31:16]}, {16'h0, miss + 16'h1});
    // Chain descriptor leading to a virtual buffer, ended by the watchdog
    put_desc(32'h120, 32'h8000_0000, 32'h8000_0000, 32'h0, 32'h140);
    put_desc(32'h140, 32'h8000_0000, 32'h6000_0000, 32'h0020_0010, 32'h180);
    i_mem.mem[32'h180 >> 2] = 32'h8000_0003;
    ack_delay <= 4'h3;
    send_frame(4, 8'h70, 3'h7, 5'h13);
    wait_idle;
    chk("chain_word0", word(32'h120), 32'h8000_0000);
    chk("status_f4", word(32'h140) & 32'h8000_FFDF, 32'h0000_D300);
    chk_buf(32'h610, 1, 8'h70);
    apb(1'b0, rxdesc_pkg::STAT_OFS, 32'h0000_0000);
    chk("wd_sticky", {31'h0, rd[rxdesc_pkg::STATB_WD]}, 32'h0000_0001);
    apb(1'b1, rxdesc_pkg::STAT_OFS, 32'h0000_0020);
    apb(1'b0, rxdesc_pkg::STAT_OFS, 32'h0000_0000);
    chk("wd_clear", {31'h0, rd[rxdesc_pkg::STATB_WD]}, 32'h0000_0000);
    // Runt dropped, then passed
    ack_delay <= 4'h0;
    put_desc(32'h150, 32'h8000_0000, 32'h0, 32'h0010_0000, 32'h700);
    send_frame(8, 8'h80, 3'h0, 5'h05);
    wait_idle;
    chk("runt_dropped", word(32'h150), 32'h8000_0000);
    apb(1'b1, rxdesc_pkg::MODE_OFS, 32'h0000_010A);
    send_frame(8, 8'h80, 3'h5, 5'h05);
    wait_idle;
    chk("status_runt", word(32'h150) & 32'hFFFF_FFDF, 32'h0008_9B00);
    // Chaining disabled: small buffer truncates the frame
    put_desc(32'h160, 32'h8000_0000, 32'h0, 32'h0004_0000, 32'h740);
    i_mem.mem[32'h744 >> 2] = 32'h5A5A_5A5A;
    apb(1'b1, rxdesc_pkg::MODE_OFS, 32'h0000_0182);
    send_frame(8, 8'h90, 3'h0, 5'h00);
    wait_idle;
    chk("status_bo", word(32'h160) & 32'h8000_FFDF, 32'h0000_1700);
    chk("bo_limit", word(32'h744), 32'h5A5A_5A5A);
    tally_and_finish;
  end

  // A hang counts as a failure
  initial begin
    #200000;
    mismatches++;
    $display("mismatch watchdog expired");
    tally_and_finish;
  end
endmodule
